// *** hw/trs_pkg.sv ***
// Package for the telemetry rate scheduler: register map, field
// layout, reserved masks, stream table and clock constants.
// Assumes a single 100 MHz clock and a 32-bit Avalon-MM register bus.
package trs_pkg;

    // Clock rate; one timer step per cycle
    localparam int CLK_PERIOD_NS = 10;
    localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
    localparam int ACC_W         = 28;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_RAW_SENSOR_RATES       = 6'h01;
    localparam logic [5:0] IDX_TEMP_AND_ALL_RAW_RATES = 6'h02;
    localparam logic [5:0] IDX_PROCESSED_SENSOR_RATES = 6'h03;
    localparam logic [5:0] IDX_ALL_PROCESSED_RATE     = 6'h04;
    localparam logic [5:0] IDX_SCHED_STATUS           = 6'h05;

    localparam logic [31:0] RATE_RESET = 32'h0000_0000;

    // Writable bits; reserved bits read as zero
    localparam logic [31:0] MASK_RATES1 = 32'hffff_ff00;
    localparam logic [31:0] MASK_RATES2 = 32'hff00_00ff;
    localparam logic [31:0] MASK_RATES3 = 32'hffff_ff00;
    localparam logic [31:0] MASK_RATES4 = 32'h0000_00ff;

    // Field low-bit positions, all fields 8 bits wide
    localparam int POS_ACCEL   = 24;
    localparam int POS_GYRO    = 16;
    localparam int POS_MAG     = 8;
    localparam int POS_TEMP    = 24;
    localparam int POS_ALL     = 0;

    // Status register layout
    localparam int POS_STAT_PEND   = 0;
    localparam int POS_STAT_ACTIVE = 16;

    // Stream numbering, also arbitration priority (lowest first)
    localparam int N_STREAMS  = 9;
    localparam int S_RAW_ACC  = 0;
    localparam int S_RAW_GYR  = 1;
    localparam int S_RAW_MAG  = 2;
    localparam int S_TEMP     = 3;
    localparam int S_ALL_RAW  = 4;
    localparam int S_PRC_ACC  = 5;
    localparam int S_PRC_GYR  = 6;
    localparam int S_PRC_MAG  = 7;
    localparam int S_ALL_PRC  = 8;

    // Batch start address and length, indexed by stream number
    localparam logic [8:0][7:0] PKT_START = {
        8'h61, 8'h6c, 8'h64, 8'h68, 8'h56, 8'h5f, 8'h5c, 8'h56, 8'h59};
    localparam logic [8:0][3:0] PKT_LEN = {
        4'hc, 4'h4, 4'h4, 4'h4, 4'hb, 4'h2, 4'h3, 4'h3, 4'h3};

endpackage : trs_pkg

// *** hw/trs_period_timer.sv ***
// One per-stream period timer: a phase accumulator adding the rate in
// Hz every clock and wrapping at the clock rate, so it fires rate
// times per second on average. Same clock domain as the scheduler.
`timescale 1ns/10ps
module trs_period_timer
    import trs_pkg::*;
#(
    parameter int CLK_FREQ = CLK_HZ,
    parameter int W        = ACC_W
) (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       enable_i,
    input  wire logic [7:0] rate_hz_i,
    output logic            expire_o
);

    typedef struct packed {
        logic [W-1:0] acc;
        logic         fire;
    } trs_tmr_t;

    localparam logic [W:0] WRAP = (W+1)'(CLK_FREQ);

    trs_tmr_t st;
    trs_tmr_t next_st;
    logic [W:0] sum;

    always_comb begin
        next_st = st;
        sum     = {1'b0, st.acc} + {{(W-7){1'b0}}, rate_hz_i};
        next_st.fire = 1'b0;
        if (!enable_i) begin
            next_st.acc = '0;
        end else if (sum >= WRAP) begin
            next_st.acc  = W'(sum - WRAP);
            next_st.fire = 1'b1;
        end else begin
            next_st.acc = W'(sum);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign expire_o = st.fire;

endmodule : trs_period_timer

// *** hw/trs_scheduler.sv ***
// Telemetry rate scheduler: four rate registers on an Avalon-MM slave,
// nine period timers, pending flags and a one-deep packet request.
// Assumes the packet port's consumer formats and sends each batch.
`timescale 1ns/10ps
module trs_scheduler
    import trs_pkg::*;
#(
    parameter int CLK_FREQ = CLK_HZ
) (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             pkt_valid_o,
    input  wire logic        pkt_ready_i,
    output logic      [7:0]  pkt_start_o,
    output logic      [3:0]  pkt_len_o,
    output logic      [3:0]  pkt_stream_o
);

    typedef struct packed {
        logic [31:0]          raw_sensor_rates;
        logic [31:0]          temp_and_all_raw_rates;
        logic [31:0]          processed_sensor_rates;
        logic [31:0]          all_processed_rate;
        logic [N_STREAMS-1:0] pend;
        logic                 pkt_valid;
        logic [7:0]           pkt_start;
        logic [3:0]           pkt_len;
        logic [3:0]           pkt_stream;
        logic                 ack;
        logic [31:0]          rdata;
    } trs_state_t;

    trs_state_t st;
    trs_state_t next_st;

    logic [N_STREAMS-1:0][7:0] rate_hz;
    logic [N_STREAMS-1:0]      active;
    logic [N_STREAMS-1:0]      expire;
    logic                      all_raw_on;
    logic                      all_prc_on;
    logic                      req;
    logic [5:0]                idx;
    logic                      aligned;

    // Merge write data into a register under byte enables and mask
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be,
                                          input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res & mask;
    endfunction : merge

    assign rate_hz[S_RAW_ACC] = st.raw_sensor_rates[POS_ACCEL +: 8];
    assign rate_hz[S_RAW_GYR] = st.raw_sensor_rates[POS_GYRO +: 8];
    assign rate_hz[S_RAW_MAG] = st.raw_sensor_rates[POS_MAG +: 8];
    assign rate_hz[S_TEMP]    = st.temp_and_all_raw_rates[POS_TEMP +: 8];
    assign rate_hz[S_ALL_RAW] = st.temp_and_all_raw_rates[POS_ALL +: 8];
    assign rate_hz[S_PRC_ACC] = st.processed_sensor_rates[POS_ACCEL +: 8];
    assign rate_hz[S_PRC_GYR] = st.processed_sensor_rates[POS_GYRO +: 8];
    assign rate_hz[S_PRC_MAG] = st.processed_sensor_rates[POS_MAG +: 8];
    assign rate_hz[S_ALL_PRC] = st.all_processed_rate[POS_ALL +: 8];

    assign all_raw_on = rate_hz[S_ALL_RAW] != 8'h00;
    assign all_prc_on = rate_hz[S_ALL_PRC] != 8'h00;

    always_comb begin
        for (int i = 0; i < N_STREAMS; i++) begin
            active[i] = rate_hz[i] != 8'h00;
        end
        active[S_RAW_ACC] = active[S_RAW_ACC] & ~all_raw_on;
        active[S_RAW_GYR] = active[S_RAW_GYR] & ~all_raw_on;
        active[S_RAW_MAG] = active[S_RAW_MAG] & ~all_raw_on;
        active[S_TEMP]    = active[S_TEMP] & ~all_raw_on;
        active[S_PRC_ACC] = active[S_PRC_ACC] & ~all_prc_on;
        active[S_PRC_GYR] = active[S_PRC_GYR] & ~all_prc_on;
        active[S_PRC_MAG] = active[S_PRC_MAG] & ~all_prc_on;
    end

    for (genvar g = 0; g < N_STREAMS; g++) begin : g_tmr
        trs_period_timer #(
            .CLK_FREQ (CLK_FREQ),
            .W        (ACC_W)
        ) u_tmr (
            .mclk_i    (mclk_i),
            .sys_rst_i (sys_rst_i),
            .enable_i  (active[g]),
            .rate_hz_i (rate_hz[g]),
            .expire_o  (expire[g])
        );
    end

    assign req     = avs_read_i | avs_write_i;
    assign idx     = avs_address_i[7:2];
    assign aligned = avs_address_i[1:0] == 2'b00;

    always_comb begin
        logic [N_STREAMS-1:0] pend;
        logic                 free;
        next_st = st;
        pend    = st.pend;
        free    = 1'b0;

        // Bus: first cycle latches read data, second cycle completes
        next_st.ack = req & ~st.ack;
        if (req && !st.ack) begin
            next_st.rdata = 32'h0000_0000;
            if (aligned && avs_read_i) begin
                unique case (idx)
                    IDX_RAW_SENSOR_RATES:
                        next_st.rdata = st.raw_sensor_rates;
                    IDX_TEMP_AND_ALL_RAW_RATES:
                        next_st.rdata = st.temp_and_all_raw_rates;
                    IDX_PROCESSED_SENSOR_RATES:
                        next_st.rdata = st.processed_sensor_rates;
                    IDX_ALL_PROCESSED_RATE:
                        next_st.rdata = st.all_processed_rate;
                    IDX_SCHED_STATUS: begin
                        next_st.rdata[POS_STAT_PEND +: N_STREAMS] =
                            st.pend;
                        next_st.rdata[POS_STAT_ACTIVE +: N_STREAMS] =
                            active;
                    end
                    default: next_st.rdata = 32'h0000_0000;
                endcase
            end
        end
        // Write lands on the edge where waitrequest is low
        if (avs_write_i && st.ack && aligned) begin
            unique case (idx)
                IDX_RAW_SENSOR_RATES:
                    next_st.raw_sensor_rates = merge(st.raw_sensor_rates,
                        avs_writedata_i, avs_byteenable_i, MASK_RATES1);
                IDX_TEMP_AND_ALL_RAW_RATES:
                    next_st.temp_and_all_raw_rates =
                        merge(st.temp_and_all_raw_rates, avs_writedata_i,
                              avs_byteenable_i, MASK_RATES2);
                IDX_PROCESSED_SENSOR_RATES:
                    next_st.processed_sensor_rates =
                        merge(st.processed_sensor_rates, avs_writedata_i,
                              avs_byteenable_i, MASK_RATES3);
                IDX_ALL_PROCESSED_RATE:
                    next_st.all_processed_rate =
                        merge(st.all_processed_rate, avs_writedata_i,
                              avs_byteenable_i, MASK_RATES4);
                default: ;
            endcase
        end

        // Packet slot empties when the consumer takes it
        if (st.pkt_valid && pkt_ready_i) begin
            next_st.pkt_valid = 1'b0;
        end
        free = !st.pkt_valid || pkt_ready_i;

        // Lowest stream number wins; one packet issued per cycle
        if (free) begin
            for (int i = N_STREAMS - 1; i >= 0; i--) begin
                if (pend[i] && active[i]) begin
                    next_st.pkt_valid  = 1'b1;
                    next_st.pkt_start  = PKT_START[i];
                    next_st.pkt_len    = PKT_LEN[i];
                    next_st.pkt_stream = 4'(i);
                end
            end
            for (int i = 0; i < N_STREAMS; i++) begin
                if (pend[i] && active[i]) begin
                    pend[i] = 1'b0;
                    break;
                end
            end
        end
        // drop pending of disabled streams; new expiry wins
        next_st.pend = (pend & active) | (expire & active);
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st                        <= '0;
            st.raw_sensor_rates       <= RATE_RESET;
            st.temp_and_all_raw_rates <= RATE_RESET;
            st.processed_sensor_rates <= RATE_RESET;
            st.all_processed_rate     <= RATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Combinational waitrequest: holds off exactly one cycle
    assign avs_waitrequest_o = req & ~st.ack;
    assign avs_readdata_o    = st.rdata;
    assign pkt_valid_o       = st.pkt_valid;
    assign pkt_start_o       = st.pkt_start;
    assign pkt_len_o         = st.pkt_len;
    assign pkt_stream_o      = st.pkt_stream;

endmodule : trs_scheduler

// *** sim/trs_sva.sv ***
// Port-level checker for trs_scheduler, attached by bind.
// Assumes one clock domain and synchronous active-high reset.
`timescale 1ns/10ps
module trs_sva (
    input wire logic        mclk_i,
    input wire logic        sys_rst_i,
    input wire logic [7:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        pkt_valid_o,
    input wire logic        pkt_ready_i,
    input wire logic [7:0]  pkt_start_o,
    input wire logic [3:0]  pkt_len_o,
    input wire logic [3:0]  pkt_stream_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    // Start and length by stream, stream 8 first
    localparam logic [8:0][11:0] TBL = {12'h61c, 12'h6c4, 12'h644,
        12'h684, 12'h56b, 12'h5f2, 12'h5c3, 12'h563, 12'h593};
    // Bits that must read zero at each address
    function automatic logic [31:0] resv(input logic [7:0] a);
        case (a)
            8'h04, 8'h0c: return 32'h0000_00ff;
            8'h08:        return 32'h00ff_ff00;
            8'h10:        return 32'hffff_ff00;
            8'h14:        return 32'hfe00_fe00;
            default:      return 32'hffff_ffff;
        endcase
    endfunction : resv
    wait_first_a: assert property ($rose(avs_read_i || avs_write_i)
        |-> avs_waitrequest_o) else $error("no wait cycle");
    wait_one_a: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o) else $error("long wait");
    wait_idle_a: assert property (!(avs_read_i || avs_write_i)
        |-> !avs_waitrequest_o) else $error("idle wait");
    resv_zero_a: assert property (avs_read_i && !avs_waitrequest_o
        |-> (avs_readdata_o & resv(avs_address_i)) == 32'h0)
        else $error("reserved bits set");
    rdata_hold_a: assert property (avs_read_i && !avs_waitrequest_o
        |=> $stable(avs_readdata_o)) else $error("read data moved");
    pkt_hold_a: assert property (pkt_valid_o && !pkt_ready_i
        |=> pkt_valid_o && $stable({pkt_start_o, pkt_len_o, pkt_stream_o}))
        else $error("offer withdrawn");
    pkt_table_a: assert property (pkt_valid_o |->
        {pkt_start_o, pkt_len_o} == TBL[pkt_stream_o])
        else $error("bad batch");
    rst_quiet_a: assert property ($fell(sys_rst_i) |->
        !pkt_valid_o ##1 !pkt_valid_o) else $error("packet after reset");
endmodule : trs_sva

bind trs_scheduler trs_sva chk_u (.mclk_i, .sys_rst_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .pkt_valid_o, .pkt_ready_i,
    .pkt_start_o, .pkt_len_o, .pkt_stream_o);

// *** sim/trs_consumer.sv ***
// Packet sink model: takes offers with a set share of stalls.
// Assumes the scheduler's valid/ready packet port, same clock.
`timescale 1ns/10ps
module trs_consumer (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [6:0] stall_pct_i,
    output logic            pkt_ready_o
);
    // Ready ignores valid, as a busy sink may drop it at any time
    always @(posedge mclk_i) begin
        if (sys_rst_i)
            pkt_ready_o <= 1'b0;
        else
            pkt_ready_o <= ($urandom_range(99, 0) >= stall_pct_i);
    end
endmodule : trs_consumer

// *** sim/test_telemetry_rate_scheduler.sv ***
// Self-checking bench for trs_scheduler against a rate model.
// Assumes a shortened timer base of FREQ cycles per second.
`timescale 1ns/10ps
module test_telemetry_rate_scheduler;
    localparam int FREQ = 1000;
    localparam int WIN  = 3000;
    logic        mclk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [7:0]  avs_address_i = 8'h00;
    logic        avs_read_i = 1'b0;
    logic        avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'h0;
    logic [31:0] avs_readdata_o, q, d;
    logic        avs_waitrequest_o, pkt_valid_o, pkt_ready_i;
    logic [7:0]  pkt_start_o;
    logic [3:0]  pkt_len_o, pkt_stream_o;
    logic [6:0]  stall = 7'd40;
    logic [8:0]  av;
    logic [31:0] rg [1:4] = '{default: 32'h0};
    logic [31:0] msk [1:4] = '{32'hffffff00, 32'hff0000ff, 32'hffffff00,
                               32'h000000ff};
    logic [7:0]  ad [9] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h00,
                            8'h18, 8'hfc, 8'h05};
    int st [9] = '{89, 86, 92, 95, 86, 104, 100, 108, 97};
    int ln [9] = '{3, 3, 3, 2, 11, 4, 4, 4, 12};
    int ri [9] = '{1, 1, 1, 2, 2, 3, 3, 3, 4};
    int ps [9] = '{24, 16, 8, 24, 0, 24, 16, 8, 0};
    int cnt [9];
    int e;
    int fails = 0;
    int n_compared = 0;

    always #5 mclk_i = ~mclk_i;

    trs_scheduler #(.CLK_FREQ(FREQ)) dut_u (.mclk_i, .sys_rst_i,
        .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
        .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
        .pkt_valid_o, .pkt_ready_i, .pkt_start_o, .pkt_len_o, .pkt_stream_o);
    trs_consumer part_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .stall_pct_i(stall), .pkt_ready_o(pkt_ready_i));

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, input logic [3:0] be);
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        // Wait for the slave; only the watchdog ends a hang
        do begin
            @(posedge mclk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (wr && a[1:0] == 2'b00 && a[7:2] inside {[1:4]})
            for (int b = 0; b < 4; b++)
                if (be[b])
                    rg[a[7:2]][8*b+:8] = wd[8*b+:8] & msk[a[7:2]][8*b+:8];
    endtask : bus

    function automatic int eff(input int s);
        logic [7:0] r;
        r = 8'(rg[ri[s]] >> ps[s]);
        if (s < 4 && rg[2][7:0] != 8'h00)
            r = 8'h00;
        if (s > 4 && s < 8 && rg[4][7:0] != 8'h00)
            r = 8'h00;
        return int'(r);
    endfunction : eff

    always @(posedge mclk_i) begin
        if (!sys_rst_i && pkt_valid_o === 1'b1 && pkt_ready_i === 1'b1) begin
            if (pkt_stream_o < 4'h9) begin
                chk({20'h0, pkt_start_o, pkt_len_o}, {20'h0,
                    st[pkt_stream_o][7:0], ln[pkt_stream_o][3:0]});
                cnt[pkt_stream_o]++;
            end else
                chk({28'h0, pkt_stream_o}, 32'h8);
        end
    end

    initial begin
        void'($urandom(32'hd0cc));
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        foreach (ad[i]) bus(1'b0, ad[i], 32'h0, 4'h0);
        foreach (ad[i]) if (i > 3) bus(1'b1, ad[i], 32'hffffffff, 4'hf);
        foreach (ad[i]) begin
            bus(1'b0, ad[i], 32'h0, 4'h0);
            chk(q, 32'h0);
        end
        for (int k = 0; k < 6; k++) begin
            for (int i = 1; i < 5; i++) bus(1'b1, 8'(i * 4), 32'h0, 4'hf);
            repeat (30) @(posedge mclk_i);
            stall <= (k > 3) ? 7'd0 : 7'd40;
            for (int i = 1; i < 5; i++) begin
                d = $urandom;
                for (int b = 0; b < 4; b++)
                    if (msk[i][8*b])
                        d[8*b+:8] = (k > 3) ? 8'h00 : 8'($urandom_range(6, 0));
                if ((i == 2 && !k[0]) || (i == 4 && !k[1]))
                    d[7:0] = 8'h00;
                if (k == 4 && i == 1)
                    d[31:24] = 8'hff;
                if (k == 5 && i == 4)
                    d[7:0] = 8'hff;
                bus(1'b1, 8'(i * 4), d, (k > 3) ? 4'hf : 4'($urandom));
            end
            for (int i = 1; i < 5; i++) begin
                bus(1'b0, 8'(i * 4), 32'h0, 4'h0);
                chk(q, rg[i]);
            end
            for (int s = 0; s < 9; s++) av[s] = (eff(s) != 0);
            bus(1'b0, 8'h14, 32'h0, 4'h0);
            chk({23'h0, q[24:16]}, {23'h0, av});
            #1 cnt = '{default: 0};
            repeat (WIN) @(posedge mclk_i);
            #1;
            for (int s = 0; s < 9; s++) begin
                e = eff(s) * WIN / FREQ;
                // Timer phase allows one packet either way; none if off
                if (e > 0 && cnt[s] >= e - 1 && cnt[s] <= e + 1)
                    cnt[s] = e;
                chk(32'(cnt[s]), 32'(e));
            end
        end
        give_verdict();
    end

    initial begin
        repeat (40000) @(posedge mclk_i);
        fails++;
        give_verdict();
    end
endmodule : test_telemetry_rate_scheduler
